// >>> shared/cos_pkg.sv
/*
 * Constants, register map and carrier types of the clock output select and
 * monitor block. Assumes one 100 MHz system clock and an Avalon-MM slave port.
 */

package cos_pkg;

   localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
   // Longest gap between fast oscillator edges before a failure is declared
   localparam int unsigned FAIL_TIMEOUT_NS = 1000;
   localparam int unsigned FAIL_TIMEOUT_CYC =
      (FAIL_TIMEOUT_NS * (CLK_FREQ_HZ / 1_000_000)) / 1000;
   localparam int unsigned MON_CNT_W       = 8;

   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;

   localparam logic [ADDR_W-1:0] CLK_MAIN_CTRL_OFS     = 5'h00;
   localparam logic [ADDR_W-1:0] CLK_CONFIG_0_OFS      = 5'h04;
   localparam logic [ADDR_W-1:0] CLK_BACKUP_CTRL_OFS   = 5'h08;
   localparam logic [ADDR_W-1:0] CLK_INTERRUPT_REG_OFS = 5'h0C;
   localparam logic [ADDR_W-1:0] RTC_COUNT_OFS         = 5'h10;

   // clk_main_ctrl fields
   localparam int unsigned MC_FAST_EN     = 0;
   localparam int unsigned MC_FAST_BYPASS = 1;
   localparam int unsigned MC_MON_EN      = 2;
   localparam int unsigned MC_PLL_EN      = 3;
   localparam int unsigned MC_FAST_READY  = 4;
   // clk_config_0 fields
   localparam int unsigned CF_SYS_SEL_LSB = 0;
   localparam int unsigned CF_PLL_SRC_LSB = 2;
   localparam int unsigned CF_CKO_SEL_LSB = 4;
   localparam int unsigned CF_CKO_WIDE    = 8;
   // clk_backup_ctrl fields
   localparam int unsigned BC_SLOW_EN     = 0;
   localparam int unsigned BC_SLOW_BYPASS = 1;
   localparam int unsigned BC_RTC_SRC_LSB = 2;
   localparam int unsigned BC_RTC_EN      = 4;
   // clk_interrupt_reg fields
   localparam int unsigned IR_FAIL_FLAG   = 0;

   localparam logic [1:0] SYS_SEL_RC8M = 2'h0;
   localparam logic [1:0] SYS_SEL_FAST = 2'h1;
   localparam logic [1:0] SYS_SEL_PLL  = 2'h2;

   localparam logic [1:0] PLL_SRC_FAST = 2'h0;
   localparam logic [1:0] PLL_SRC_RC8M = 2'h1;
   localparam logic [1:0] PLL_SRC_RC48 = 2'h2;

   localparam logic [1:0] RTC_SRC_NONE = 2'h0;
   localparam logic [1:0] RTC_SRC_SLOW = 2'h1;
   localparam logic [1:0] RTC_SRC_RC40 = 2'h2;

   localparam logic [3:0] CKO_CODE_NONE = 4'h0;
   localparam logic [3:0] CKO_NARROW_MASK = 4'h7;

   // Dividers: main PLL/2, third PLL/2, RC 48M/8, USB PLL/32
   localparam int unsigned DIV_N   = 4;
   localparam int unsigned DIV_W   = 5;
   localparam int unsigned DIV_TAP [DIV_N] = '{0, 0, 2, 4};

   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_DRAIN = 3'b010,
      ST_ARM   = 3'b100
   } cos_mux_state_t;

   typedef struct packed {
      logic system_clock;
      logic int_rc_8m;
      logic fast_pin_a;
      logic main_pll_clock;
      logic second_pll_clock;
      logic third_pll_clock;
      logic external_input_clock;
      logic int_rc_48m;
      logic usb_pll_clock;
      logic slow_fast_pin_a_pin;
      logic int_rc_40k;
      logic main_pwr_ok;
   } cos_clk_src_t;

   typedef struct packed {
      logic       fast_osc_amp_en;
      logic       fast_osc_bypass_en;
      logic       slow_osc_amp_en;
      logic       slow_osc_bypass_en;
      logic       pll_en;
      logic [1:0] pll_src_sel;
      logic [1:0] sys_clk_sel;
   } cos_clk_ctrl_t;

endpackage

// >>> design/cos_clock_output_select.sv
/*
 * Clock control block: oscillator enables and bypass, PLL source and system
 * clock selection, glitch-free clock output mux, fast oscillator failure
 * monitor with NMI, and a real-time counter on a slow clock.
 * Assumes all clock sources arrive asynchronously and well below CLK/2,
 * and that registers are reached over Avalon-MM with waitrequest.
 */
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module cos_clock_output_select (
   input  wire logic                          CLK,
   input  wire logic                          RST_B,
   input  wire logic [cos_pkg::ADDR_W-1:0]    AVS_ADDRESS,
   input  wire logic                          AVS_READ,
   input  wire logic                          AVS_WRITE,
   input  wire logic [cos_pkg::DATA_W-1:0]    AVS_WRITEDATA,
   input  wire logic [3:0]                    AVS_BYTEENABLE,
   output logic      [cos_pkg::DATA_W-1:0]    AVS_READDATA,
   output logic                               AVS_WAITREQUEST,
   input  wire cos_pkg::cos_clk_src_t         CLK_SRC,
   output cos_pkg::cos_clk_ctrl_t             CLK_CTRL,
   output logic                               CLKOUT_PIN,
   output logic                               FAST_OSC_FAIL_NMI
);

   localparam int unsigned SRC_W = $bits(cos_pkg::cos_clk_src_t);

   // Synchronisers and edge detection
   logic [SRC_W-1:0]          sync1_ff;
   logic [SRC_W-1:0]          sync2_ff;
   logic [SRC_W-1:0]          prev_ff;
   cos_pkg::cos_clk_src_t     src_s;
   cos_pkg::cos_clk_src_t     src_rise;

   // Software registers
   logic                      fast_en_ff;
   logic                      fast_bypass_ff;
   logic                      mon_en_ff;
   logic                      pll_en_ff;
   logic [1:0]                sys_sel_ff;
   logic [1:0]                pll_src_ff;
   logic [3:0]                cko_sel_ff;
   logic                      cko_wide_ff;
   logic                      slow_en_ff;
   logic                      slow_bypass_ff;
   logic [1:0]                rtc_src_ff;
   logic                      rtc_en_ff;
   logic                      fail_flag_ff;
   logic [31:0]               rtc_cnt_ff;

   // Bus
   logic                      ack_ff;
   logic [cos_pkg::DATA_W-1:0] rdata_ff;
   logic                      wr_take;
   logic [31:0]               be_mask;
   logic [31:0]               img_main;
   logic [31:0]               img_cfg;
   logic [31:0]               img_bkp;
   logic [31:0]               img_int;
   logic [31:0]               nxt_main;
   logic [31:0]               nxt_cfg;
   logic [31:0]               nxt_bkp;
   logic                      wr_main;
   logic                      wr_cfg;
   logic                      wr_bkp;
   logic                      wr_int;

   // Monitor
   logic [cos_pkg::MON_CNT_W-1:0] mon_cnt_ff;
   logic                      edge_seen_ff;
   logic                      fast_ready;
   logic                      fail_det;
   logic                      fail_hits_sys;

   // Dividers and output mux
   logic [cos_pkg::DIV_N-1:0] div_rise;
   logic [cos_pkg::DIV_N-1:0] div_out;
   logic [15:0]               src_vec;
   logic [3:0]                req_code;
   logic [3:0]                act_code_ff;
   cos_pkg::cos_mux_state_t   state_ff;
   logic                      clkout_ff;

   // RTC
   logic                      rtc_tick;
   logic                      rtc_hold;

   // Every source is asynchronous: two flip-flops before any use
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff  <= '0;
      end else begin
         sync1_ff <= CLK_SRC;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   assign src_s    = sync2_ff;
   assign src_rise = sync2_ff & ~prev_ff;

   // Fast oscillator monitor
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         mon_cnt_ff   <= '0;
         edge_seen_ff <= 1'b0;
      end else if (!fast_en_ff || src_rise.fast_pin_a) begin
         mon_cnt_ff   <= '0;
         edge_seen_ff <= fast_en_ff;
      end else if (mon_cnt_ff != cos_pkg::MON_CNT_W'(cos_pkg::FAIL_TIMEOUT_CYC)) begin
         mon_cnt_ff   <= mon_cnt_ff + 1'b1;
      end
   end

   assign fast_ready = edge_seen_ff &&
      (mon_cnt_ff != cos_pkg::MON_CNT_W'(cos_pkg::FAIL_TIMEOUT_CYC));
   assign fail_det = mon_en_ff && fast_en_ff &&
      (mon_cnt_ff == cos_pkg::MON_CNT_W'(cos_pkg::FAIL_TIMEOUT_CYC));
   assign fail_hits_sys = (sys_sel_ff == cos_pkg::SYS_SEL_FAST) ||
      ((sys_sel_ff == cos_pkg::SYS_SEL_PLL) && (pll_src_ff == cos_pkg::PLL_SRC_FAST));

   // Register images and byte-lane merge
   always_comb begin
      be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                 {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
      img_main = '0;
      img_main[cos_pkg::MC_FAST_EN]     = fast_en_ff;
      img_main[cos_pkg::MC_FAST_BYPASS] = fast_bypass_ff;
      img_main[cos_pkg::MC_MON_EN]      = mon_en_ff;
      img_main[cos_pkg::MC_PLL_EN]      = pll_en_ff;
      img_main[cos_pkg::MC_FAST_READY]  = fast_ready;
      img_cfg = '0;
      img_cfg[cos_pkg::CF_SYS_SEL_LSB +: 2] = sys_sel_ff;
      img_cfg[cos_pkg::CF_PLL_SRC_LSB +: 2] = pll_src_ff;
      img_cfg[cos_pkg::CF_CKO_SEL_LSB +: 4] = cko_sel_ff;
      img_cfg[cos_pkg::CF_CKO_WIDE]         = cko_wide_ff;
      img_bkp = '0;
      img_bkp[cos_pkg::BC_SLOW_EN]          = slow_en_ff;
      img_bkp[cos_pkg::BC_SLOW_BYPASS]      = slow_bypass_ff;
      img_bkp[cos_pkg::BC_RTC_SRC_LSB +: 2] = rtc_src_ff;
      img_bkp[cos_pkg::BC_RTC_EN]           = rtc_en_ff;
      img_int = '0;
      img_int[cos_pkg::IR_FAIL_FLAG]        = fail_flag_ff;
      nxt_main = (img_main & ~be_mask) | (AVS_WRITEDATA & be_mask);
      nxt_cfg  = (img_cfg & ~be_mask) | (AVS_WRITEDATA & be_mask);
      nxt_bkp  = (img_bkp & ~be_mask) | (AVS_WRITEDATA & be_mask);
   end

   // Every access takes two cycles: decode, then answer
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_ff;
   assign AVS_READDATA    = rdata_ff;
   assign wr_take = AVS_WRITE && ack_ff;
   assign wr_main = wr_take && (AVS_ADDRESS == cos_pkg::CLK_MAIN_CTRL_OFS);
   assign wr_cfg  = wr_take && (AVS_ADDRESS == cos_pkg::CLK_CONFIG_0_OFS);
   assign wr_bkp  = wr_take && (AVS_ADDRESS == cos_pkg::CLK_BACKUP_CTRL_OFS);
   assign wr_int  = wr_take && (AVS_ADDRESS == cos_pkg::CLK_INTERRUPT_REG_OFS);

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ack_ff   <= 1'b0;
         rdata_ff <= '0;
      end else begin
         ack_ff <= (AVS_READ || AVS_WRITE) && !ack_ff;
         if (AVS_READ && !ack_ff) begin
            case (AVS_ADDRESS)
               cos_pkg::CLK_MAIN_CTRL_OFS:     rdata_ff <= img_main;
               cos_pkg::CLK_CONFIG_0_OFS:      rdata_ff <= img_cfg;
               cos_pkg::CLK_BACKUP_CTRL_OFS:   rdata_ff <= img_bkp;
               cos_pkg::CLK_INTERRUPT_REG_OFS: rdata_ff <= img_int;
               cos_pkg::RTC_COUNT_OFS:         rdata_ff <= rtc_cnt_ff;
               default:                        rdata_ff <= '0;
            endcase
         end
      end
   end

   // Main control: a failure beats a write in the same cycle
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         fast_en_ff     <= 1'b0;
         fast_bypass_ff <= 1'b0;
         mon_en_ff      <= 1'b0;
         pll_en_ff      <= 1'b0;
      end else begin
         if (wr_main) begin
            fast_en_ff     <= nxt_main[cos_pkg::MC_FAST_EN];
            fast_bypass_ff <= nxt_main[cos_pkg::MC_FAST_BYPASS];
            mon_en_ff      <= nxt_main[cos_pkg::MC_MON_EN];
            pll_en_ff      <= nxt_main[cos_pkg::MC_PLL_EN];
         end
         if (fail_det) begin
            fast_en_ff <= 1'b0;
            if (fail_hits_sys) begin
               pll_en_ff <= 1'b0;
            end
         end
      end
   end

   // Clock configuration
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         sys_sel_ff  <= cos_pkg::SYS_SEL_RC8M;
         pll_src_ff  <= cos_pkg::PLL_SRC_RC8M;
         cko_sel_ff  <= cos_pkg::CKO_CODE_NONE;
         cko_wide_ff <= 1'b0;
      end else begin
         if (wr_cfg) begin
            sys_sel_ff  <= nxt_cfg[cos_pkg::CF_SYS_SEL_LSB +: 2];
            pll_src_ff  <= nxt_cfg[cos_pkg::CF_PLL_SRC_LSB +: 2];
            cko_sel_ff  <= nxt_cfg[cos_pkg::CF_CKO_SEL_LSB +: 4];
            cko_wide_ff <= nxt_cfg[cos_pkg::CF_CKO_WIDE];
         end
         if (fail_det && fail_hits_sys) begin
            sys_sel_ff <= cos_pkg::SYS_SEL_RC8M;
         end
      end
   end

   // Backup domain control
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         slow_en_ff     <= 1'b0;
         slow_bypass_ff <= 1'b0;
         rtc_src_ff     <= cos_pkg::RTC_SRC_NONE;
         rtc_en_ff      <= 1'b0;
      end else if (wr_bkp) begin
         slow_en_ff     <= nxt_bkp[cos_pkg::BC_SLOW_EN];
         slow_bypass_ff <= nxt_bkp[cos_pkg::BC_SLOW_BYPASS];
         rtc_src_ff     <= nxt_bkp[cos_pkg::BC_RTC_SRC_LSB +: 2];
         rtc_en_ff      <= nxt_bkp[cos_pkg::BC_RTC_EN];
      end
   end

   // Failure flag: write 1 clears, a new failure in the same cycle wins
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         fail_flag_ff <= 1'b0;
      end else if (fail_det) begin
         fail_flag_ff <= 1'b1;
      end else if (wr_int && AVS_BYTEENABLE[0] && AVS_WRITEDATA[cos_pkg::IR_FAIL_FLAG]) begin
         fail_flag_ff <= 1'b0;
      end
   end

   assign FAST_OSC_FAIL_NMI = fail_flag_ff;

   // Registered oscillator and PLL controls
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         CLK_CTRL <= '0;
      end else begin
         CLK_CTRL.fast_osc_amp_en    <= fast_en_ff && !fast_bypass_ff;
         CLK_CTRL.fast_osc_bypass_en <= fast_en_ff && fast_bypass_ff;
         CLK_CTRL.slow_osc_amp_en    <= slow_en_ff && !slow_bypass_ff;
         CLK_CTRL.slow_osc_bypass_en <= slow_en_ff && slow_bypass_ff;
         CLK_CTRL.pll_en             <= pll_en_ff;
         CLK_CTRL.pll_src_sel        <= pll_src_ff;
         CLK_CTRL.sys_clk_sel        <= sys_sel_ff;
      end
   end

   // Dividers count rising edges of the synchronised clocks
   assign div_rise = {src_rise.usb_pll_clock, src_rise.int_rc_48m,
                      src_rise.third_pll_clock, src_rise.main_pll_clock};

   genvar gi;
   generate
      for (gi = 0; gi < cos_pkg::DIV_N; gi = gi + 1) begin : g_div
         logic [cos_pkg::DIV_W-1:0] cnt_ff;
         always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
               cnt_ff <= '0;
            end else if (div_rise[gi]) begin
               cnt_ff <= cnt_ff + 1'b1;
            end
         end
         assign div_out[gi] = cnt_ff[cos_pkg::DIV_TAP[gi]];
      end
   endgenerate

   // Source table indexed by the wide code; unused codes stay low
   always_comb begin
      src_vec     = '0;
      src_vec[4]  = src_s.system_clock;
      src_vec[5]  = src_s.int_rc_8m;
      src_vec[6]  = src_s.fast_pin_a && fast_en_ff;
      src_vec[7]  = div_out[0];
      src_vec[8]  = src_s.second_pll_clock;
      src_vec[9]  = div_out[1];
      src_vec[10] = src_s.external_input_clock;
      src_vec[11] = src_s.third_pll_clock;
      src_vec[12] = src_s.int_rc_48m;
      src_vec[13] = div_out[2];
      src_vec[14] = div_out[3];
      src_vec[15] = 1'b0;
   end

   // Narrow mode: the top select bit is ignored, so 0xx maps to silent codes
   assign req_code = cko_wide_ff ? cko_sel_ff : (cko_sel_ff & cos_pkg::CKO_NARROW_MASK);

   // Glitch-free switch: finish the old high phase, then wait for the new low
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_ff    <= cos_pkg::ST_RUN;
         act_code_ff <= cos_pkg::CKO_CODE_NONE;
         clkout_ff   <= 1'b0;
      end else begin
         case (state_ff)
            cos_pkg::ST_RUN: begin
               clkout_ff <= src_vec[act_code_ff];
               if (req_code != act_code_ff) begin
                  state_ff <= cos_pkg::ST_DRAIN;
               end
            end
            cos_pkg::ST_DRAIN: begin
               clkout_ff <= src_vec[act_code_ff];
               if (!src_vec[act_code_ff]) begin
                  state_ff <= cos_pkg::ST_ARM;
               end
            end
            cos_pkg::ST_ARM: begin
               clkout_ff <= 1'b0;
               if (!src_vec[req_code]) begin
                  act_code_ff <= req_code;
                  state_ff    <= cos_pkg::ST_RUN;
               end
            end
            default: begin
               state_ff  <= cos_pkg::ST_RUN;
               clkout_ff <= 1'b0;
            end
         endcase
      end
   end

   assign CLKOUT_PIN = clkout_ff;

   // Real-time counter; the 40 kHz RC source halts it without main power
   always_comb begin
      case (rtc_src_ff)
         cos_pkg::RTC_SRC_SLOW: rtc_tick = src_rise.slow_fast_pin_a_pin && slow_en_ff;
         cos_pkg::RTC_SRC_RC40: rtc_tick = src_rise.int_rc_40k;
         default:               rtc_tick = 1'b0;
      endcase
   end

   assign rtc_hold = (rtc_src_ff == cos_pkg::RTC_SRC_RC40) && !src_s.main_pwr_ok;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rtc_cnt_ff <= '0;
      end else if (rtc_en_ff && rtc_tick && !rtc_hold) begin
         rtc_cnt_ff <= rtc_cnt_ff + 1'b1;
      end
   end

endmodule // cos_clock_output_select

`default_nettype wire

// >>> verification/cos_clock_output_select_properties.sv
/* Port-level checker of the clock output block.
   Assumes one clock domain and the block's bus timing. */
`timescale 1ns/1ps
`default_nettype none

module cos_clock_output_select_properties (
   input wire logic                       CLK,
   input wire logic                       RST_B,
   input wire logic [cos_pkg::ADDR_W-1:0] AVS_ADDRESS,
   input wire logic                       AVS_READ,
   input wire logic                       AVS_WRITE,
   input wire logic [cos_pkg::DATA_W-1:0] AVS_WRITEDATA,
   input wire logic [3:0]                 AVS_BYTEENABLE,
   input wire logic [cos_pkg::DATA_W-1:0] AVS_READDATA,
   input wire logic                       AVS_WAITREQUEST,
   input wire cos_pkg::cos_clk_ctrl_t     CLK_CTRL,
   input wire logic                       CLKOUT_PIN,
   input wire logic                       FAST_OSC_FAIL_NMI
);
   logic       mon_en_ff;
   logic [3:0] cko_sel_ff;
   logic       wide_ff;
   logic [7:0] quiet_cnt_ff;
   logic       wr_ok;
   logic       cfg_wr;
   logic       silent;
   logic       clr_wr;

   assign wr_ok  = AVS_WRITE && !AVS_WAITREQUEST;
   assign cfg_wr = wr_ok && AVS_ADDRESS == cos_pkg::CLK_CONFIG_0_OFS;
   assign clr_wr = wr_ok && AVS_ADDRESS == cos_pkg::CLK_INTERRUPT_REG_OFS
                   && AVS_BYTEENABLE[0] && AVS_WRITEDATA[0];
   assign silent = wide_ff ? (cko_sel_ff[3:2] == 2'h0 || cko_sel_ff == 4'hF) : !cko_sel_ff[2];

   // Monitor enable as software last wrote it
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         mon_en_ff <= 1'b0;
      end else if (wr_ok && AVS_ADDRESS == cos_pkg::CLK_MAIN_CTRL_OFS && AVS_BYTEENABLE[0]) begin
         mon_en_ff <= AVS_WRITEDATA[cos_pkg::MC_MON_EN];
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cko_sel_ff <= 4'h0;
         wide_ff    <= 1'b0;
      end else if (cfg_wr) begin
         if (AVS_BYTEENABLE[0]) cko_sel_ff <= AVS_WRITEDATA[7:4];
         if (AVS_BYTEENABLE[1]) wide_ff <= AVS_WRITEDATA[8];
      end
   end

   // Cycles since the last config write, saturating
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         quiet_cnt_ff <= 8'h00;
      end else if (cfg_wr) begin
         quiet_cnt_ff <= 8'h00;
      end else if (quiet_cnt_ff != 8'hFF) begin
         quiet_cnt_ff <= quiet_cnt_ff + 8'h01;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   AST_WAIT_FIRST: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
      else $error("no wait state");
   AST_WAIT_ONE: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("more than one wait state");
   AST_SILENT_LOW: assert property (silent && quiet_cnt_ff == 8'hFF |-> !CLKOUT_PIN)
      else $error("clock output active on a no-clock code");
   AST_NO_RUNT: assert property ($rose(CLKOUT_PIN) |=> CLKOUT_PIN)
      else $error("one-cycle pulse on clock output");
   AST_FAIL_NEEDS_MON: assert property ($rose(FAST_OSC_FAIL_NMI) |-> mon_en_ff)
      else $error("failure raised with monitor disabled");
   AST_FAIL_OSC_OFF: assert property ($rose(FAST_OSC_FAIL_NMI) |-> ##[0:1]
      (!CLK_CTRL.fast_osc_amp_en && !CLK_CTRL.fast_osc_bypass_en))
      else $error("fast osc on after failure");
   AST_FAIL_SYS_RC: assert property ($rose(FAST_OSC_FAIL_NMI)
      && $past(CLK_CTRL.sys_clk_sel) == cos_pkg::SYS_SEL_FAST
      |-> ##[0:1] CLK_CTRL.sys_clk_sel == cos_pkg::SYS_SEL_RC8M)
      else $error("system clock not moved to RC 8M");
   AST_FAIL_PLL_OFF: assert property ($rose(FAST_OSC_FAIL_NMI)
      && $past(CLK_CTRL.sys_clk_sel) == cos_pkg::SYS_SEL_FAST |-> ##[0:1] !CLK_CTRL.pll_en)
      else $error("PLL not switched off on failure");
   AST_NMI_HOLDS: assert property (FAST_OSC_FAIL_NMI && !clr_wr |=> FAST_OSC_FAIL_NMI)
      else $error("NMI dropped without a clear");
   AST_FLAG_READ: assert property (AVS_READ && !AVS_WAITREQUEST
      && AVS_ADDRESS == cos_pkg::CLK_INTERRUPT_REG_OFS && $past(FAST_OSC_FAIL_NMI)
      |-> AVS_READDATA[cos_pkg::IR_FAIL_FLAG])
      else $error("failure flag reads 0 while raised");
endmodule // cos_clock_output_select_properties

bind cos_clock_output_select cos_clock_output_select_properties u_props (
   .CLK(CLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CLK_CTRL(CLK_CTRL),
   .CLKOUT_PIN(CLKOUT_PIN), .FAST_OSC_FAIL_NMI(FAST_OSC_FAIL_NMI));

`default_nettype wire

// >>> verification/cos_clk_partner.sv
/* Free-running clock sources and main power flag seen by the block.
   Assumes every half period spans at least 3 CLK periods. */
`timescale 1ns/1ps
`default_nettype none

module cos_clk_partner (
   input  wire logic            FAST_RUN,
   input  wire logic            PWR_OK,
   output cos_pkg::cos_clk_src_t SRC
);
   localparam int HALF [11] = '{130, 150, 30, 110, 100, 90, 80, 70, 50, 60, 40};
   wire [11:1] raw;

   for (genvar i = 0; i < 11; i++) begin : g_src
      logic tick;
      initial begin
         tick = 1'b0;
         forever #(HALF[i]) tick = ~tick;
      end
      assign raw[i+1] = tick;
   end

   // A stopped crystal holds low
   assign SRC = {raw[11:10], raw[9] & FAST_RUN, raw[8:1], PWR_OK};
endmodule // cos_clk_partner

`default_nettype wire

// >>> verification/tb_top.sv
/* Bench: bus tasks, one task per scenario, verdict.
   Assumes package, design, partner and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic                       clk;
   logic                       rst_b;
   logic [cos_pkg::ADDR_W-1:0] avs_address;
   logic                       avs_read;
   logic                       avs_write;
   logic [31:0]                avs_writedata;
   logic [31:0]                avs_readdata;
   logic                       avs_waitrequest;
   cos_pkg::cos_clk_src_t      clk_src;
   cos_pkg::cos_clk_ctrl_t     clk_ctrl;
   logic                       clkout_pin;
   logic                       nmi;
   logic                       fast_run;
   logic                       pwr_ok;
   logic [31:0]                rd;
   logic [31:0]                held;
   int                         failures;
   int                         total_checks;

   cos_clock_output_select dut (
      .CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .CLK_SRC(clk_src),
      .CLK_CTRL(clk_ctrl), .CLKOUT_PIN(clkout_pin), .FAST_OSC_FAIL_NMI(nmi));
   cos_clk_partner u_src (.FAST_RUN(fast_run), .PWR_OK(pwr_ok), .SRC(clk_src));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic give_verdict;
      if (failures == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask

   task automatic t_reset;
      rdchk(5'h00, 32'h0, "main ctrl reset");
      rdchk(5'h04, 32'h4, "config reset");
      rdchk(5'h08, 32'h0, "backup reset");
      rdchk(5'h0C, 32'h0, "flag reset");
      bus(1'b1, 5'h18, 32'hFFFFFFFF);
      rdchk(5'h18, 32'h0, "unmapped");
   endtask

   task automatic t_bypass;
      bus(1'b1, 5'h00, 32'h3);
      bus(1'b1, 5'h08, 32'h3);
      repeat (3) @(posedge clk);
      check("fast bypass", clk_ctrl.fast_osc_bypass_en, 32'h1);
      check("fast amp", clk_ctrl.fast_osc_amp_en, 32'h0);
      check("slow bypass", clk_ctrl.slow_osc_bypass_en, 32'h1);
   endtask

   task automatic t_pll_src;
      for (int s = 0; s < 3; s++) begin
         bus(1'b1, 5'h04, s << 2);
         repeat (3) @(posedge clk);
         check("pll source", clk_ctrl.pll_src_sel, s);
      end
   endtask

   task automatic t_clkout;
      int hi;
      int nz;
      logic act;
      bus(1'b1, 5'h00, 32'h1);
      for (int c = 0; c < 24; c++) begin
         bus(1'b1, 5'h04, (c < 8) ? c << 4 : 32'h100 | ((c - 8) << 4));
         act = (c < 8) ? c[2] : (c >= 12 && c != 23);
         repeat (200) @(posedge clk);
         hi = 0;
         nz = 0;
         repeat (300) begin
            @(posedge clk);
            if (clkout_pin === 1'b1) hi++;
            if (clkout_pin !== 1'b0) nz++;
         end
         check($sformatf("clkout code %0d", c), act ? (hi > 0 && hi < 300) : (nz == 0), 1);
      end
   endtask

   task automatic t_nomon;
      bus(1'b1, 5'h00, 32'h1);
      repeat (200) @(posedge clk);
      fast_run <= 1'b0;
      repeat (300) @(posedge clk);
      check("nmi unmonitored", nmi, 32'h0);
      rdchk(5'h00, 32'h1, "fast kept on");
      fast_run <= 1'b1;
   endtask

   task automatic t_monitor;
      bus(1'b1, 5'h00, 32'h1);
      repeat (200) @(posedge clk);
      bus(1'b1, 5'h04, 32'h1);
      bus(1'b1, 5'h00, 32'hD);
      repeat (300) @(posedge clk);
      check("nmi idle", nmi, 32'h0);
      fast_run <= 1'b0;
      repeat (150) @(posedge clk);
      check("nmi", nmi, 32'h1);
      check("sys sel", clk_ctrl.sys_clk_sel, cos_pkg::SYS_SEL_RC8M);
      check("pll en", clk_ctrl.pll_en, 32'h0);
      check("fast amp off", clk_ctrl.fast_osc_amp_en, 32'h0);
      rdchk(5'h00, 32'h4, "main ctrl after fail");
      rdchk(5'h04, 32'h0, "config after fail");
      rdchk(5'h0C, 32'h1, "fail flag");
      bus(1'b1, 5'h0C, 32'h1);
      rdchk(5'h0C, 32'h0, "flag cleared");
      check("nmi cleared", nmi, 32'h0);
      bus(1'b1, 5'h00, 32'h0);
   endtask

   task automatic t_rtc;
      bus(1'b1, 5'h08, 32'h18);
      repeat (100) @(posedge clk);
      pwr_ok <= 1'b0;
      repeat (10) @(posedge clk);
      bus(1'b0, 5'h10, 32'h0);
      held = rd;
      check("rtc ran", held != 0, 32'h1);
      repeat (200) @(posedge clk);
      rdchk(5'h10, held, "rtc frozen");
      pwr_ok <= 1'b1;
      repeat (200) @(posedge clk);
      bus(1'b0, 5'h10, 32'h0);
      check("rtc resumed", rd > held && rd - held <= 10, 32'h1);
      held = rd;
      bus(1'b1, 5'h08, 32'h15);
      pwr_ok <= 1'b0;
      repeat (300) @(posedge clk);
      bus(1'b0, 5'h10, 32'h0);
      check("rtc slow", rd > held, 32'h1);
      check("slow amp", clk_ctrl.slow_osc_amp_en, 32'h1);
   endtask

   initial begin
      rst_b         = 1'b0;
      avs_address   = '0;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = '0;
      fast_run      = 1'b1;
      pwr_ok        = 1'b1;
      failures      = 0;
      total_checks  = 0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset;
      t_bypass;
      t_pll_src;
      t_clkout;
      t_nomon;
      t_monitor;
      t_rtc;
      give_verdict;
   end

   initial begin
      #800_000;
      failures++;
      give_verdict;
   end
endmodule // tb_top

`default_nettype wire
